/* flash_seq.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Sequencer: decodes data register accesses into flash operations
// ----------------------------------------------------------------------------
module flash_seq
   import flash_path_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        dat_wr,
   input  wire logic        dat_rd,
   input  wire logic [7:0]  dat_wbyte,
   input  wire logic        adr_wr,
   input  wire logic [15:0] adr_wdata,
   input  wire logic [2:0]  write_mode_select,
   input  wire logic [3:0]  read_mode_select,
   output logic [9:0]       data_word,
   output logic [15:0]      addr_word,
   flash_mem_if.seq         mem
);
   typedef struct packed {
      op_state_type st;
      logic [7:0]   byte_value_field;
      logic         fail;
      logic [15:0]  addr;
      logic         unread;
      logic         req;
   } seq_type;

   seq_type q;
   seq_type d;
   logic    idle;
   logic    start_rd;

   // Next state of the sequencer
   always_comb begin
      d        = q;
      d.req    = 1'b0;
      idle     = (q.st == OP_IDLE);
      start_rd = dat_rd && idle &&
                 ((read_mode_select == RD_BLOCK) ||
                  (read_mode_select == RD_SINGLE && !q.unread));
      if (dat_rd) begin
         d.unread = 1'b0;
      end
      if (adr_wr && idle) begin
         d.addr = adr_wdata;
      end
      case (q.st)
         OP_IDLE: begin
            if (dat_wr) begin
               d.byte_value_field = dat_wbyte;
               if (write_mode_select == WR_PROGRAM) begin
                  d.st  = OP_WRITE;
                  d.req = 1'b1;
               end else if (write_mode_select == WR_ERASE && dat_wbyte == ERASE_KEY) begin
                  d.st  = OP_ERASE;
                  d.req = 1'b1;
               end
            end else if (start_rd) begin
               d.st  = OP_READ;
               d.req = 1'b1;
            end
         end
         OP_READ, OP_WRITE, OP_ERASE: begin
            if (mem.done) begin
               d.fail = mem.fail;
               if (q.st != OP_ERASE) begin
                  d.addr = q.addr + ADDR_STEP;
               end
               if (q.st == OP_READ) begin
                  d.byte_value_field = mem.rdata;
                  d.unread           = 1'b1;
               end
               d.st = OP_IDLE;
            end
         end
         default: d.st = OP_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{OP_IDLE, DATA_RESET[BYTE_HI:BYTE_LO], 1'b0, ADDR_RESET, 1'b0, 1'b0};
      end else begin
         q <= d;
      end
   end

   assign mem.req   = q.req;
   assign mem.wr    = (q.st == OP_WRITE);
   assign mem.erase = (q.st == OP_ERASE);
   assign mem.addr  = q.addr;
   assign mem.wdata = q.byte_value_field;
   assign data_word = {q.byte_value_field, q.fail, !idle};
   assign addr_word = q.addr;

   // Checks
   a_busy_blocks: assert property (@(posedge clk) disable iff (!rst_n)
      (q.st != OP_IDLE && !mem.done) |=> (d.req == 1'b0 && !q.req))
      else $error("operation started while busy");
   a_addr_step: assert property (@(posedge clk) disable iff (!rst_n)
      (mem.done && q.st inside {OP_READ, OP_WRITE}) |=> (q.addr == $past(q.addr) + ADDR_STEP))
      else $error("address not incremented");
   a_fail_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !mem.done |=> $stable(q.fail))
      else $error("fail flag changed without completion");
   a_fail_load: assert property (@(posedge clk) disable iff (!rst_n)
      (mem.done && q.st != OP_IDLE) |=> (data_word[FAIL_BIT] == $past(mem.fail)))
      else $error("fail flag not loaded");
   a_busy_bit: assert property (@(posedge clk) disable iff (!rst_n)
      q.req |-> data_word[BUSY_BIT])
      else $error("busy low during request");
   a_erase_key: assert property (@(posedge clk) disable iff (!rst_n)
      (idle && dat_wr && write_mode_select == WR_ERASE && dat_wbyte != ERASE_KEY)
      |=> q.st == OP_IDLE)
      else $error("erase without key");
   a_prog_start: assert property (@(posedge clk) disable iff (!rst_n)
      (idle && dat_wr && write_mode_select == WR_PROGRAM) |=> (q.req && mem.wr))
      else $error("program not started");
   a_single_read: assert property (@(posedge clk) disable iff (!rst_n)
      (idle && dat_rd && !dat_wr && read_mode_select == RD_SINGLE && q.unread)
      |=> q.st == OP_IDLE)
      else $error("single read restarted before collection");
   a_block_read: assert property (@(posedge clk) disable iff (!rst_n)
      (idle && dat_rd && !dat_wr && read_mode_select == RD_BLOCK) |=> q.st == OP_READ)
      else $error("block read not started");
endmodule : flash_seq
`default_nettype wire

/* flash_path_pkg.sv */
// ----------------------------------------------------------------------------
// Constants of the test-port flash data and address path
// ----------------------------------------------------------------------------
package flash_path_pkg;
   localparam int          DATA_W      = 10;
   localparam int          ADDR_W      = 16;
   localparam int          BYTE_HI     = 9;
   localparam int          BYTE_LO     = 2;
   localparam int          FAIL_BIT    = 1;
   localparam int          BUSY_BIT    = 0;
   localparam logic [9:0]  DATA_RESET  = 10'h000;
   localparam logic [15:0] ADDR_RESET  = 16'h0000;
   localparam logic [15:0] ADDR_STEP   = 16'h0001;
   localparam logic [7:0]  ERASE_KEY   = 8'hA5;
   localparam logic [2:0]  WR_NONE     = 3'h0;
   localparam logic [2:0]  WR_PROGRAM  = 3'h1;
   localparam logic [2:0]  WR_ERASE    = 3'h2;
   localparam logic [3:0]  RD_NONE     = 4'h0;
   localparam logic [3:0]  RD_BLOCK    = 4'h1;
   localparam logic [3:0]  RD_SINGLE   = 4'h2;

   typedef enum logic [3:0] {
      OP_IDLE  = 4'b0001,
      OP_READ  = 4'b0010,
      OP_WRITE = 4'b0100,
      OP_ERASE = 4'b1000
   } op_state_type;
endpackage : flash_path_pkg

/* flash_mem_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Request and answer between sequencer and flash array port
// ----------------------------------------------------------------------------
interface flash_mem_if;
   logic        req;     // One-cycle request pulse
   logic        wr;      // Program request
   logic        erase;   // Page erase request
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        done;    // One-cycle completion pulse
   logic        fail;    // Valid with done
   logic [7:0]  rdata;   // Valid with done
   modport seq (output req, wr, erase, addr, wdata, input done, fail, rdata);
   modport mem (input req, wr, erase, addr, wdata, output done, fail, rdata);
endinterface : flash_mem_if
`default_nettype wire

/* flash_data_path.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Top: data and address path of the test-port flash programming logic
// ----------------------------------------------------------------------------
module flash_data_path
   import flash_path_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        RESETN,
   input  wire logic        DAT_WR,
   input  wire logic        DAT_RD,
   input  wire logic [7:0]  DAT_WBYTE,
   input  wire logic        ADR_WR,
   input  wire logic [15:0] ADR_WDATA,
   input  wire logic [2:0]  WRITE_MODE_SELECT,
   input  wire logic [3:0]  READ_MODE_SELECT,
   output logic [9:0]       FLASH_DATA_PORT,
   output logic [15:0]      FLASH_ADDRESS_POINTER,
   output logic             MEM_REQ,
   output logic             MEM_WR,
   output logic             MEM_ERASE,
   output logic [15:0]      MEM_ADDR,
   output logic [7:0]       MEM_WDATA,
   input  wire logic        MEM_DONE,
   input  wire logic        MEM_FAIL,
   input  wire logic [7:0]  MEM_RDATA,
   input  wire logic        CORE_HALTED,
   output logic             WATCHDOG_RUN,
   output logic             PERIPH_RUN
);
   typedef struct packed {
      logic halt_meta;
      logic halt_sync;
   } top_type;

   top_type     q;
   top_type     d;
   flash_mem_if mem_bus ();

   // Flash operation sequencer
   flash_seq u_seq (
      .clk               (REF_CLK),
      .rst_n             (RESETN),
      .dat_wr            (DAT_WR),
      .dat_rd            (DAT_RD),
      .dat_wbyte         (DAT_WBYTE),
      .adr_wr            (ADR_WR),
      .adr_wdata         (ADR_WDATA),
      .write_mode_select (WRITE_MODE_SELECT),
      .read_mode_select  (READ_MODE_SELECT),
      .data_word         (FLASH_DATA_PORT),
      .addr_word         (FLASH_ADDRESS_POINTER),
      .mem               (mem_bus.seq)
   );

   assign MEM_REQ       = mem_bus.req;
   assign MEM_WR        = mem_bus.wr;
   assign MEM_ERASE     = mem_bus.erase;
   assign MEM_ADDR      = mem_bus.addr;
   assign MEM_WDATA     = mem_bus.wdata;
   assign mem_bus.done  = MEM_DONE;
   assign mem_bus.fail  = MEM_FAIL;
   assign mem_bus.rdata = MEM_RDATA;

   // Halt status passes two flops before use
   always_comb begin
      d           = q;
      d.halt_meta = CORE_HALTED;
      d.halt_sync = q.halt_meta;
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign WATCHDOG_RUN = !q.halt_sync;
   assign PERIPH_RUN   = 1'b1;

   a_wdt_halt: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CORE_HALTED [*3] |-> !WATCHDOG_RUN)
      else $error("watchdog running while halted");
   a_periph_run: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      CORE_HALTED |-> PERIPH_RUN)
      else $error("peripherals stopped during debug");
endmodule : flash_data_path
`default_nettype wire

/* flash_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Flash array model: answers each request after a fixed delay
// ----------------------------------------------------------------------------
module flash_mem_model #(
   parameter int          LAT       = 6,
   parameter logic [15:0] LOCK_ADDR = 16'h0100
)(
   input  wire logic        clk,
   input  wire logic        req,
   input  wire logic [15:0] addr,
   output logic             done,
   output logic             fail,
   output logic [7:0]       rdata
);
   int          cnt  = 0;
   logic [15:0] a_q  = 16'h0000;
   logic [7:0]  junk = 8'h00;

   // Latch the target and count the busy time down; junk keeps idle lines moving
   always @(posedge clk) begin
      junk <= junk + 8'h3B;
      if (req) begin
         cnt <= LAT;
         a_q <= addr;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end

   // One-cycle completion; a locked location fails, outside done the lines carry junk
   assign done  = (cnt == 1);
   assign fail  = done ? (a_q == LOCK_ADDR) : junk[0];
   assign rdata = done ? (a_q[7:0] ^ 8'h3C) : junk;
endmodule : flash_mem_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Self-checking bench of the flash data and address path
// ----------------------------------------------------------------------------
module tb;
   import flash_path_pkg::*;
   typedef struct {
      logic [2:0]  wm;
      logic [3:0]  rm;
      logic [15:0] adr;
      logic [7:0]  byt;
      logic [7:0]  e_byte;
      logic        e_fail;
      logic [15:0] e_adr;
      int          e_req;
   } row_type;
   logic        clk, rstn, dat_wr, dat_rd, adr_wr, halted, wd_run, per_run;
   logic        mem_req, mem_wr, mem_erase, mem_done, mem_fail, req_wr, req_er;
   logic [7:0]  dat_wbyte, mem_wdata, mem_rdata, req_wd;
   logic [15:0] adr_wdata, adr_port, mem_addr, req_adr;
   logic [2:0]  wm;
   logic [3:0]  rm;
   logic [9:0]  data_port;
   int          err_count = 0, n_compared = 0, n_req = 0, cyc = 0, n0;
   row_type     rows [7] = '{
      '{WR_PROGRAM, RD_NONE, 16'h0010, 8'h5A, 8'h5A, 0, 16'h0011, 1},
      '{WR_PROGRAM, RD_NONE, 16'h0100, 8'h5A, 8'h5A, 1, 16'h0101, 1},
      '{WR_ERASE, RD_NONE, 16'h0020, 8'hA5, 8'hA5, 0, 16'h0020, 1},
      '{WR_ERASE, RD_NONE, 16'h0020, 8'h33, 8'h33, 0, 16'h0020, 0},
      '{WR_NONE, RD_BLOCK, 16'h0030, 8'h00, 8'h0C, 0, 16'h0031, 1},
      '{WR_NONE, RD_BLOCK, 16'h0100, 8'h00, 8'h3C, 1, 16'h0101, 1},
      '{WR_NONE, RD_NONE, 16'h0040, 8'h77, 8'h77, 1, 16'h0040, 0}};

   flash_data_path uut (.REF_CLK(clk), .RESETN(rstn), .DAT_WR(dat_wr), .DAT_RD(dat_rd),
      .DAT_WBYTE(dat_wbyte), .ADR_WR(adr_wr), .ADR_WDATA(adr_wdata), .WRITE_MODE_SELECT(wm),
      .READ_MODE_SELECT(rm), .FLASH_DATA_PORT(data_port), .FLASH_ADDRESS_POINTER(adr_port),
      .MEM_REQ(mem_req), .MEM_WR(mem_wr), .MEM_ERASE(mem_erase), .MEM_ADDR(mem_addr),
      .MEM_WDATA(mem_wdata), .MEM_DONE(mem_done), .MEM_FAIL(mem_fail), .MEM_RDATA(mem_rdata),
      .CORE_HALTED(halted), .WATCHDOG_RUN(wd_run), .PERIPH_RUN(per_run));
   flash_mem_model mem (.clk(clk), .req(mem_req), .addr(mem_addr), .done(mem_done),
      .fail(mem_fail), .rdata(mem_rdata));

   // Clock of 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Count requests, keep the last target, cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (mem_req === 1'b1) begin
         n_req++;
         req_adr = mem_addr;
         {req_wr, req_er, req_wd} = {mem_wr, mem_erase, mem_wdata};
      end
      if (cyc == 3000) begin
         err_count++;
         close_out();
      end
   end

   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One-cycle strobe: 0 data write, 1 data read, 2 address write
   task strobe(input int k, input logic [15:0] v);
      @(posedge clk);
      #2;
      dat_wr = (k == 0);
      dat_rd = (k == 1);
      adr_wr = (k == 2);
      dat_wbyte = v[7:0];
      adr_wdata = v;
      @(posedge clk);
      #2;
      {dat_wr, dat_rd, adr_wr} = 3'h0;
   endtask : strobe

   // Poll busy low before the next access
   task idle;
      int i;
      i = 0;
      while (data_port[BUSY_BIT] !== 1'b0 && i < 50) begin
         @(posedge clk);
         #2;
         i++;
      end
      if (i == 50) check(16'h0001, 16'h0000);
   endtask : idle

   task close_out;
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   // Main sequence: reset, table rows, then hand-written cases
   initial begin
      {rstn, dat_wr, dat_rd, adr_wr, halted, dat_wbyte, adr_wdata} = '0;
      {wm, rm} = '0;
      repeat (16) @(posedge clk);
      check(data_port, DATA_RESET);
      check(adr_port, ADDR_RESET);
      check(wd_run, 1'b1);
      #2 rstn = 1'b1;
      foreach (rows[r]) begin
         wm = rows[r].wm;
         rm = rows[r].rm;
         strobe(2, rows[r].adr);
         n0 = n_req;
         strobe(int'(rows[r].rm != RD_NONE), {8'h00, rows[r].byt});
         idle();
         check(data_port[9:2], rows[r].e_byte);
         check(data_port[FAIL_BIT], rows[r].e_fail);
         check(adr_port, rows[r].e_adr);
         check(16'(n_req - n0), 16'(rows[r].e_req));
         if (rows[r].e_req != 0) check(req_adr, rows[r].adr);
         if (rows[r].e_req != 0) check(req_wr, 16'(rows[r].wm == WR_PROGRAM));
         if (rows[r].e_req != 0) check(req_er, 16'(rows[r].wm == WR_ERASE));
         if (rows[r].wm == WR_PROGRAM) check(req_wd, rows[r].byt);
      end
      // Accesses while busy start nothing
      {wm, rm} = {WR_PROGRAM, RD_NONE};
      strobe(2, 16'h0050);
      n0 = n_req;
      strobe(0, 16'h0011);
      check(data_port[BUSY_BIT], 1'b1);
      strobe(0, 16'h0022);
      strobe(2, 16'h0900);
      idle();
      check(16'(n_req - n0), 16'h0001);
      check(adr_port, 16'h0051);
      check(data_port[9:2], 8'h11);
      // Single read: collect leftover block byte, start, collect only, start again
      {wm, rm} = {WR_NONE, RD_SINGLE};
      strobe(2, 16'h0060);
      n0 = n_req;
      for (int j = 0; j < 4; j++) begin
         strobe(1, 16'h0000);
         idle();
      end
      check(16'(n_req - n0), 16'h0002);
      check(adr_port, 16'h0062);
      check(data_port[9:2], 8'h5D);
      // Halted core stops the watchdog, peripherals keep running
      halted = 1'b1;
      repeat (3) @(posedge clk);
      #2;
      check(wd_run, 1'b0);
      check(per_run, 1'b1);
      halted = 1'b0;
      repeat (3) @(posedge clk);
      #2;
      check(wd_run, 1'b1);
      // Reset in mid-operation clears busy and pointer, then a read runs again
      {wm, rm} = {WR_NONE, RD_BLOCK};
      strobe(1, 16'h0000);
      rstn = 1'b0;
      #1;
      check(data_port, DATA_RESET);
      check(adr_port, ADDR_RESET);
      repeat (2) @(posedge clk);
      #2 rstn = 1'b1;
      strobe(1, 16'h0000);
      idle();
      check(data_port, {8'h3C, 2'b00});
      check(adr_port, 16'h0001);
      close_out();
   end
endmodule : tb
`default_nettype wire
